// ### hdl/frame_header_parser.sv
// receive-side header parser and classifier for 802.15.4 frames, AXI4-Lite regs
`include "frame_header_parser_defines.svh"
`default_nettype none
module frame_header_parser (
  input wire logic clk,
  input wire logic rst,
  // received octet stream from the demodulator
  input wire logic rx_sfd,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  // transmitted frame notification for the retry engine
  input wire logic tx_done,
  input wire logic [15:0] tx_fcf,
  // stored-octet path toward the frame buffer, frame status and ack/retry flags
  output logic buf_we,
  output logic [7:0] buf_data,
  output logic frame_start,
  output logic frame_match,
  output logic ack_req,
  output logic ack_pending,
  output logic [7:0] ack_seq,
  output logic wait_ack,
  output logic tx_finished,
  output logic payload_octet,
  output logic fcs_octet,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import frame_header_parser_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic in_frame;
    logic [6:0] len;
    logic [6:0] idx;
    logic [15:0] fcf;
    logic [7:0] seq;
    logic [7:0] cmd_id;
    logic [4:0] cmd_pos;
    len_class_t lclass;
    logic buf_we;
    logic [7:0] buf_data;
    logic frame_start;
    logic frame_match;
    logic ack_req;
    logic ack_pending;
    logic [7:0] ack_seq;
    logic wait_ack;
    logic tx_finished;
    logic payload_octet;
    logic fcs_octet;
    logic dst_bcast;
    logic [15:0] dst_short;
  } state_t;

  state_t q, d;

  // ----------------------------------------------------------------
  // header decode
  // ----------------------------------------------------------------
  frame_type_t ftype;
  addr_mode_t dmode, smode;
  logic [1:0] fver;
  logic type_ok, ver_ok, fver_ack_ok, filt_pass, dreq;
  logic [4:0] hdr_len;
  logic [6:0] len_in;

  always_comb begin
    ftype = frame_type_t'(q.fcf[2:0]);
    dmode = addr_mode_t'(q.fcf[11:10]);
    smode = addr_mode_t'(q.fcf[15:14]);
    fver = q.fcf[13:12];
    type_ok = (q.fcf[2:0] <= 3'h3) || q.ctrl[`FHP_CTRL_UPLD];
    ver_ok = (fver <= 2'h1);
    // policy value n: acknowledge versions up to n, 3 acknowledges any
    fver_ack_ok = (q.ctrl[`FHP_CTRL_FVN_LO +: 2] == 2'h3) ||
                  (fver <= q.ctrl[`FHP_CTRL_FVN_LO +: 2]);
    // the security flag rejects only the 2003 version; 2003 secured is unsupported
    filt_pass = type_ok && (ver_ok || q.ctrl[`FHP_CTRL_FVN_LO +: 2] != 2'h1) &&
                !(q.fcf[`FHP_FCF_SEC] && fver == 2'h0) &&
                (ftype != FT_ACK) && (dmode >= AM_SHORT || smode >= AM_SHORT);
    // position of the command id: fcf+seq, dst pan+addr, src pan unless compressed
    hdr_len = 5'd3;
    if (dmode >= AM_SHORT) begin
      hdr_len = hdr_len + ((dmode == AM_EXT) ? 5'd10 : 5'd4);
    end
    if (smode >= AM_SHORT) begin
      hdr_len = hdr_len + ((dmode >= AM_SHORT && q.fcf[`FHP_FCF_PANC]) ? 5'd0 : 5'd2);
      hdr_len = hdr_len + ((smode == AM_EXT) ? 5'd8 : 5'd2);
    end
    dreq = (ftype == FT_CMD) && (q.cmd_id == `FHP_CMD_DATA_REQ);
    len_in = rx_data[6:0];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [31:0] max_cyc;

  always_comb begin
    d = q;
    d.buf_we = 1'b0;
    d.frame_start = 1'b0;
    d.frame_match = 1'b0;
    d.ack_req = 1'b0;
    d.tx_finished = 1'b0;
    d.payload_octet = 1'b0;
    d.fcs_octet = 1'b0;
    case (rate_t'(q.ctrl[`FHP_CTRL_RATE_LO +: 2]))
      RATE_250: max_cyc = 32'(`FHP_PSDU_US_250 * (`FHP_CLK_HZ / 1000000));
      RATE_500: max_cyc = 32'(`FHP_PSDU_US_500 * (`FHP_CLK_HZ / 1000000));
      RATE_1000: max_cyc = 32'(`FHP_PSDU_US_1000 * (`FHP_CLK_HZ / 1000000));
      default: max_cyc = 32'(`FHP_PSDU_US_2000 * (`FHP_CLK_HZ / 1000000));
    endcase

    // receive path
    if (rx_sfd) begin
      d.in_frame = 1'b1;
      d.idx = 7'd0;
      d.len = 7'd0;
    end else if (rx_valid && q.in_frame) begin
      if (q.len == 7'd0 && q.idx == 7'd0) begin
        if (len_in == 7'd0) begin
          d.in_frame = 1'b0;
        end else begin
          d.len = len_in;
          d.frame_start = 1'b1;
          d.buf_we = 1'b1;
          d.buf_data = rx_data; // bit 7 passes through untouched
          d.fcf = 16'h0000;
          d.cmd_id = 8'h00;
          d.cmd_pos = 5'd31;
          d.dst_bcast = 1'b0;
          if (len_in < `FHP_LEN_ACK) d.lclass = LC_RESERVED;
          else if (len_in == `FHP_LEN_ACK) d.lclass = LC_ACK;
          else if (len_in < `FHP_LEN_MPDU_MIN) d.lclass = LC_RESERVED;
          else d.lclass = LC_MPDU;
        end
      end else begin
        d.idx = q.idx + 7'd1;
        d.buf_we = 1'b1;
        d.buf_data = rx_data;
        if (q.idx == 7'd0) d.fcf[7:0] = rx_data;
        if (q.idx == 7'd1) d.fcf[15:8] = rx_data;
        if (q.idx == 7'd2) begin
          d.seq = rx_data;
          d.cmd_pos = hdr_len;
        end
        if (q.idx == 7'd5) d.dst_short[7:0] = rx_data;
        if (q.idx == 7'd6) d.dst_short[15:8] = rx_data;
        if (q.idx == 7'(q.cmd_pos)) d.cmd_id = rx_data;
        // widened so the last octet of a 127-octet frame cannot wrap into the payload
        if ({1'b0, q.idx} + 8'd2 >= {1'b0, q.len}) d.fcs_octet = 1'b1;
        else d.payload_octet = 1'b1;
        if (q.idx + 7'd1 == q.len) d.in_frame = 1'b0;
      end
    end
    if (q.idx == 7'd7) begin
      d.dst_bcast = (dmode == AM_SHORT) && (q.dst_short == `FHP_BCAST);
    end

    // end of frame: filter and auto acknowledgement
    if (rx_end && q.len != 7'd0 && q.lclass != LC_RESERVED) begin
      d.len = 7'd0;
      d.idx = 7'd0;
      d.in_frame = 1'b0;
      d.frame_match = filt_pass;
      if (q.ctrl[`FHP_CTRL_AACK] && filt_pass && q.fcf[`FHP_FCF_AREQ] && !q.dst_bcast &&
          (ftype == FT_DATA || ftype == FT_CMD) && fver_ack_ok) begin
        d.ack_req = 1'b1;
        d.ack_seq = q.seq;
        d.ack_pending = dreq && q.ctrl[`FHP_CTRL_PEND];
      end
    end else if (rx_end) begin
      d.len = 7'd0;
      d.idx = 7'd0;
      d.in_frame = 1'b0;
    end

    // transmit side of auto retry
    if (tx_done && q.ctrl[`FHP_CTRL_ARET]) begin
      if (tx_fcf[`FHP_FCF_AREQ]) d.wait_ack = 1'b1;
      else begin
        d.wait_ack = 1'b0;
        d.tx_finished = 1'b1;
      end
    end else if (q.wait_ack && rx_end && q.lclass == LC_ACK) begin
      d.wait_ack = 1'b0;
      d.tx_finished = 1'b1;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    if (s_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_awaddr;
    end
    if (s_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.w_data = s_wdata;
      d.w_strb0 = s_wstrb[0];
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      if (q.aw_addr == `FHP_OFF_CTRL) begin
        if (q.w_strb0) d.ctrl = q.w_data[7:0];
      end else begin
        d.bresp = 2'b10;
      end
    end
    if (q.bvalid && s_bready) d.bvalid = 1'b0;
    if (s_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0000_0000;
      d.rresp = 2'b00;
      case (s_araddr)
        `FHP_OFF_CTRL: d.rdata = {24'h000000, q.ctrl};
        `FHP_OFF_STATUS: d.rdata = {24'h000000, q.wait_ack, q.in_frame, q.lclass, 1'b0, q.len[2:0]};
        `FHP_OFF_FCF: d.rdata = {8'h00, q.seq, q.fcf};
        `FHP_OFF_TIMING: d.rdata = {8'h00, 8'(`FHP_ACK_CYC / 40), 8'(`FHP_SHR_CYC / 40), 8'(`FHP_PHR_CYC / 40)};
        `FHP_OFF_PSDU_T: d.rdata = max_cyc;
        default: begin
          d.rresp = 2'b10;
        end
      endcase
    end
    if (q.rvalid && s_rready) d.rvalid = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= `FHP_CTRL_RESET;
      q.lclass <= LC_INVALID;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_awready = !q.aw_got;
  assign s_wready = !q.w_got;
  assign s_arready = !q.rvalid;
  assign s_bvalid = q.bvalid;
  assign s_bresp = q.bresp;
  assign s_rvalid = q.rvalid;
  assign s_rdata = q.rdata;
  assign s_rresp = q.rresp;
  assign buf_we = q.buf_we;
  assign buf_data = q.buf_data;
  assign frame_start = q.frame_start;
  assign frame_match = q.frame_match;
  assign ack_req = q.ack_req;
  assign ack_pending = q.ack_pending;
  assign ack_seq = q.ack_seq;
  assign wait_ack = q.wait_ack;
  assign tx_finished = q.tx_finished;
  assign payload_octet = q.payload_octet;
  assign fcs_octet = q.fcs_octet;
endmodule
`default_nettype wire

// ### hdl/frame_header_parser_defines.svh
// constants for the frame header parser: offsets, fields, resets, timing
`ifndef FRAME_HEADER_PARSER_DEFINES_SVH
`define FRAME_HEADER_PARSER_DEFINES_SVH
`define FHP_CLK_HZ 40000000
// register byte offsets
`define FHP_OFF_CTRL 8'h00
`define FHP_OFF_STATUS 8'h04
`define FHP_OFF_FCF 8'h08
`define FHP_OFF_TIMING 8'h0C
`define FHP_OFF_PSDU_T 8'h10
// control fields
`define FHP_CTRL_AACK 0
`define FHP_CTRL_ARET 1
`define FHP_CTRL_UPLD 2
`define FHP_CTRL_PEND 3
`define FHP_CTRL_FVN_LO 4
`define FHP_CTRL_RATE_LO 6
`define FHP_CTRL_RESET 8'h00
// frame control fields, frame lengths, command id and broadcast address
`define FHP_FCF_SEC 3
`define FHP_FCF_PEND 4
`define FHP_FCF_AREQ 5
`define FHP_FCF_PANC 6
`define FHP_LEN_MAX 7'd127
`define FHP_LEN_ACK 7'd5
`define FHP_LEN_MPDU_MIN 7'd9
`define FHP_CMD_DATA_REQ 8'h04
`define FHP_BCAST 16'hFFFF
// on-air times
`define FHP_SHR_US 160
`define FHP_PHR_US 32
`define FHP_ACK_US 192
`define FHP_PSDU_US_250 4064
`define FHP_PSDU_US_500 2032
`define FHP_PSDU_US_1000 1016
`define FHP_PSDU_US_2000 508
`define FHP_SHR_CYC (`FHP_SHR_US * (`FHP_CLK_HZ / 1000000))
`define FHP_PHR_CYC (`FHP_PHR_US * (`FHP_CLK_HZ / 1000000))
`define FHP_ACK_CYC (`FHP_ACK_US * (`FHP_CLK_HZ / 1000000))
`endif

// ### hdl/frame_header_parser_pkg.sv
// types shared by the frame header parser
`default_nettype none
package frame_header_parser_pkg;
  typedef enum logic [2:0] {
    FT_BEACON, FT_DATA, FT_ACK, FT_CMD, FT_RES4, FT_RES5, FT_RES6, FT_RES7
  } frame_type_t;
  typedef enum logic [1:0] {AM_NONE, AM_RES, AM_SHORT, AM_EXT} addr_mode_t;
  typedef enum logic [1:0] {LC_RESERVED, LC_ACK, LC_MPDU, LC_INVALID} len_class_t;
  typedef enum logic [1:0] {RATE_250, RATE_500, RATE_1000, RATE_2000} rate_t;
endpackage
`default_nettype wire

// ### tb/fhp_checker_assertions.sv
// concurrent checks on the parser ports
`default_nettype none
module fhp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_sfd,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic tx_done,
  input wire logic [15:0] tx_fcf,
  input wire logic buf_we,
  input wire logic [7:0] buf_data,
  input wire logic frame_start,
  input wire logic frame_match,
  input wire logic ack_req,
  input wire logic wait_ack,
  input wire logic fcs_octet,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid
);
  logic hdr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // set while the next octet is the length header
  always_ff @(posedge clk) begin
    if (rst || rx_valid) hdr_q <= 1'b0;
    else if (rx_sfd) hdr_q <= 1'b1;
  end
  sequence s_hdr; hdr_q && rx_valid && rx_data[6:0] != 7'h00; endsequence
  sequence s_started; frame_start && buf_we; endsequence
  property p_len_zero;
    hdr_q && rx_valid && rx_data[6:0] == 7'h00 |=> !frame_start && !buf_we;
  endproperty
  property p_hdr; s_hdr |=> s_started ##0 buf_data == $past(rx_data); endproperty
  property p_start; frame_start |-> $past(hdr_q && rx_valid); endproperty
  property p_match; frame_match |-> $past(rx_end); endproperty
  property p_ack; ack_req |-> frame_match && $past(rx_end); endproperty
  property p_no_wait; tx_done && !tx_fcf[5] |=> !wait_ack; endproperty
  property p_wait; $rose(wait_ack) |-> $past(tx_done && tx_fcf[5]); endproperty
  property p_fcs; fcs_octet |-> buf_we; endproperty
  property p_rd; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_len_zero: assert property (p_len_zero) else $error("zero length started");
  a_hdr: assert property (p_hdr) else $error("header not stored");
  a_start: assert property (p_start) else $error("stray frame start");
  a_match: assert property (p_match) else $error("stray match");
  a_ack: assert property (p_ack) else $error("stray ack");
  a_no_wait: assert property (p_no_wait) else $error("waits unasked");
  a_wait: assert property (p_wait) else $error("wait without cause");
  a_fcs: assert property (p_fcs) else $error("fcs without store");
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule
bind frame_header_parser fhp_checker u_chk (.clk(clk), .rst(rst), .rx_sfd(rx_sfd),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .tx_done(tx_done),
  .tx_fcf(tx_fcf), .buf_we(buf_we), .buf_data(buf_data), .frame_start(frame_start),
  .frame_match(frame_match), .ack_req(ack_req), .wait_ack(wait_ack),
  .fcs_octet(fcs_octet), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid));
`default_nettype wire

// ### tb/radio_peer_model.sv
// over-air peer: frames arrive as a demodulated octet stream
`default_nettype none
module radio_peer_model (
  input wire logic clk,
  output logic rx_sfd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_sfd = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
  end
  // control field low octet first, sequence 5A, command id after a short dest
  function automatic logic [7:0] octet(input int i, input logic [7:0] p,
                                       input logic [15:0] f, input logic [7:0] c);
    case (i)
      0: return p;
      1: return f[7:0];
      2: return f[15:8];
      3: return 8'h5A;
      8: return c;
      default: return i[7:0];
    endcase
  endfunction
  // idle gaps invert the data so a stale octet never looks valid
  task automatic send(input logic [7:0] p, input logic [15:0] f, input logic [7:0] c,
                      input int gap);
    int len;
    len = int'(p[6:0]);
    @(posedge clk);
    rx_sfd <= 1'b1;
    for (int i = 0; i <= len; i++) begin
      @(posedge clk);
      rx_sfd <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= octet(i, p, f, c);
      repeat (gap) begin
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the frame header parser
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] c, p; logic [15:0] f; logic [7:0] m; logic [3:0] x;} row_t;
  // x = {start, match, ack, pending}
  row_t rows [13] = '{
    '{8'h00, 8'h00, 16'h0801, 8'h00, 4'b0000}, '{8'h00, 8'h05, 16'h0002, 8'h00, 4'b1000},
    '{8'h00, 8'h07, 16'h0801, 8'h00, 4'b1000}, '{8'h00, 8'h89, 16'h0801, 8'h00, 4'b1100},
    '{8'h00, 8'h7F, 16'h0801, 8'h00, 4'b1100}, '{8'h01, 8'h0C, 16'h0822, 8'h00, 4'b1000},
    '{8'h01, 8'h0C, 16'h0821, 8'h00, 4'b1110}, '{8'h09, 8'h0C, 16'h0823, 8'h04, 4'b1111},
    '{8'h09, 8'h0C, 16'h0823, 8'h05, 4'b1110}, '{8'h01, 8'h0C, 16'h0825, 8'h00, 4'b1000},
    '{8'h05, 8'h0C, 16'h0825, 8'h00, 4'b1100}, '{8'h01, 8'h0C, 16'h1821, 8'h00, 4'b1100},
    '{8'h11, 8'h0C, 16'h1821, 8'h00, 4'b1110}};
  int tm [4] = '{4064, 2032, 1016, 508};
  logic clk = 0, rst = 1, tx_done = 0, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0;
  logic s_bready = 1, s_rready = 1;
  logic [15:0] tx_fcf = 0;
  logic [7:0] s_awaddr = 0, s_araddr = 0, seq_q;
  logic [31:0] s_wdata = 0, d;
  logic [1:0] rs, s_bresp, s_rresp;
  logic rx_sfd, rx_valid, rx_end, buf_we, frame_start, frame_match, ack_req, ack_pending;
  logic wait_ack, s_awready, s_wready, s_bvalid, s_arready, s_rvalid, fcs_octet, pend_q;
  logic tx_finished;
  logic [7:0] rx_data, ack_seq;
  logic [31:0] s_rdata;
  int miscompares = 0, comparisons = 0, cyc = 0, n_st, n_mt, n_ak, n_we, n_fc, n_tf;
  always #12.5 clk = ~clk;
  radio_peer_model peer (.clk(clk), .rx_sfd(rx_sfd), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end));
  frame_header_parser dut (.clk(clk), .rst(rst), .rx_sfd(rx_sfd), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_done(tx_done), .tx_fcf(tx_fcf),
    .buf_we(buf_we), .buf_data(), .frame_start(frame_start), .frame_match(frame_match),
    .ack_req(ack_req), .ack_pending(ack_pending), .ack_seq(ack_seq), .wait_ack(wait_ack),
    .tx_finished(tx_finished), .payload_octet(), .fcs_octet(fcs_octet), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  always @(posedge clk) begin
    cyc++;
    if (frame_start) n_st++;
    if (frame_match) n_mt++;
    if (buf_we) n_we++;
    if (fcs_octet) n_fc++;
    if (tx_finished) n_tf++;
    if (ack_req) begin
      n_ak++;
      pend_q <= ack_pending;
      seq_q <= ack_seq;
    end
    if (cyc == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bready and rready stay high, so each answer is taken at its first edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    rs = s_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    d = s_rdata;
    rs = s_rresp;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00);
    chk(d, 0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(8'h00, {24'h0, rows[i].c});
      {n_st, n_mt, n_ak, n_we, n_fc} = 0;
      peer.send(rows[i].p, rows[i].f, rows[i].m, i % 2);
      repeat (3) @(posedge clk);
      chk(n_st, rows[i].x[3]);
      chk(n_mt, rows[i].x[2]);
      chk(n_ak, rows[i].x[1]);
      chk(n_we, n_st ? rows[i].p[6:0] + 1 : 0);
      if (rows[i].x[1]) chk({pend_q, seq_q}, {rows[i].x[0], 8'h5A});
      if (rows[i].p[6:0] >= 9) chk(n_fc, 2);
      if (rows[i].x[2]) begin
        rd(8'h08);
        chk(d, {8'h00, 8'h5A, rows[i].f});
      end
      $display("frame row %0d done", i);
    end
    for (int r = 0; r < 4; r++) begin
      wr(8'h00, r << 6);
      rd(8'h10);
      chk(d, tm[r] * 40);
    end
    rd(8'h0C);
    chk(d, 32'h00C0A020);
    rd(8'h14);
    chk(rs, 2'b10);
    chk(d, 32'h0);
    wr(8'h14, 32'h0);
    chk(rs, 2'b10);
    $display("rate and map test done");
    wr(8'h00, 32'h02);
    n_tf = 0;
    tx_fcf <= 16'h0821;
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    @(posedge clk);
    chk(wait_ack, 1);
    peer.send(8'h05, 16'h0002, 8'h00, 0);
    repeat (2) @(posedge clk);
    chk(wait_ack, 0);
    tx_fcf <= 16'h0801;
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    @(posedge clk);
    chk(wait_ack, 0);
    @(posedge clk);
    chk(n_tf, 2);
    $display("retry test done");
    wrap_up();
  end
endmodule
`default_nettype wire
